/* File: src/mgmt_mem_pkg.sv */
// constants for the paged management memory block
// shared by the top module and its byte memory
package mgmt_mem_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam int PAGE_BYTES = 128;
  // byte offsets of the lower-region selector bytes
  localparam logic [6:0] BANK_SEL_OFS = 7'h7e;
  localparam logic [6:0] PAGE_SEL_OFS = 7'h7f;
  // implemented pages; a slot is picked per page and bank
  localparam logic [7:0] PAGE_00 = 8'h00;
  localparam logic [7:0] PAGE_01 = 8'h01;
  localparam logic [7:0] PAGE_02 = 8'h02;
  localparam logic [7:0] PAGE_10 = 8'h10;
  localparam logic [7:0] PAGE_11 = 8'h11;
  localparam logic [7:0] BANK_0 = 8'h00;
  localparam int SLOT_W = 3;
  localparam logic [2:0] SLOT_LOWER = 3'h0;
  localparam logic [2:0] SLOT_P00 = 3'h1;
  localparam logic [2:0] SLOT_P01 = 3'h2;
  localparam logic [2:0] SLOT_P02 = 3'h3;
  localparam logic [2:0] SLOT_P10 = 3'h4;
  localparam logic [2:0] SLOT_P11 = 3'h5;
  localparam int MEM_WORDS = 6 * PAGE_BYTES;
  localparam int MEM_AW = 10;
  // wishbone word offsets (byte address = 4 * index)
  localparam logic [9:0] WIN_BASE = 10'h000; // 256 window bytes
  localparam logic [9:0] CTRL_OFS = 10'h100;
  localparam logic [9:0] STAT_OFS = 10'h101;
  localparam logic [9:0] SEL_OFS = 10'h102;
  // control register fields
  localparam int CTRL_FLAT_BIT = 0;
  localparam int CTRL_INT_BIT = 1;
  localparam int CTRL_ADV_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;
endpackage

/* File: src/mgmt_byte_ram.sv */
// single-port byte memory holding the lower region and all pages
// one access per cycle; read data come out of a register
`timescale 1ns/1ps
module mgmt_byte_ram (
  input wire logic clk_i, // system clock
  input wire logic we_i, // write strobe
  input wire logic [9:0] addr_i, // byte address
  input wire logic [7:0] wdata_i, // write byte
  output logic [7:0] rdata_o // registered read byte
);
  logic [7:0] mem_ff [0:mgmt_mem_pkg::MEM_WORDS-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_ff[addr_i];
  end
endmodule

/* File: src/module_mgmt_memory_paging.sv */
// paged management memory seen through a 256-byte window
// assumes a classic wishbone master and synchronous sideband inputs
`timescale 1ns/1ps
module module_mgmt_memory_paging (
  input wire logic clk_i, // 125 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [11:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic module_reset_input_n_i, // host reset, active low
  input wire logic module_lowpower_input_n_i, // host low power, low
  input wire logic int_event_i, // module event raising interrupt
  output logic interrupt_reset_line_o, // interrupt level, active high
  output logic lowpower_present_line_o, // presence pull-down value
  output logic lowpower_present_line_oe_n_o, // pull-down enable, low
  output logic module_in_reset_o, // module held in reset
  output logic module_lowpower_o // module in low-power mode
);
  logic [2:0] ctrl_ff;
  logic [7:0] page_sel_ff;
  logic [7:0] bank_sel_ff;
  logic int_flag_ff;
  logic rst_req_ff;
  logic lp_req_ff;
  mgmt_mem_pkg::bus_state_e state_ff;
  mgmt_mem_pkg::bus_state_e nxt_state;
  logic [9:0] word_idx;
  logic [7:0] win_addr;
  logic win_hit;
  logic ctrl_hit;
  logic stat_hit;
  logic sel_hit;
  logic req;
  logic flat_mode;
  logic paged_ok;
  logic [2:0] slot;
  logic slot_ok;
  logic [9:0] ram_addr;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic sel_page_wr;
  logic sel_bank_wr;
  logic [31:0] nxt_dat;

  assign req = wb_cyc_i && wb_stb_i;
  assign word_idx = wb_adr_i[11:2];
  assign win_addr = word_idx[7:0];
  assign flat_mode = ctrl_ff[mgmt_mem_pkg::CTRL_FLAT_BIT];
  // extra pages only in paged mode (control bit 0 clear) or when advertised
  assign paged_ok = !flat_mode
    || ctrl_ff[mgmt_mem_pkg::CTRL_ADV_BIT];

  always_comb begin
    win_hit = 1'b0;
    ctrl_hit = 1'b0;
    stat_hit = 1'b0;
    sel_hit = 1'b0;
    if (word_idx[9:8] == mgmt_mem_pkg::WIN_BASE[9:8]) begin
      win_hit = 1'b1;
    end else if (word_idx == mgmt_mem_pkg::CTRL_OFS) begin
      ctrl_hit = 1'b1;
    end else if (word_idx == mgmt_mem_pkg::STAT_OFS) begin
      stat_hit = 1'b1;
    end else if (word_idx == mgmt_mem_pkg::SEL_OFS) begin
      sel_hit = 1'b1;
    end
  end

  // map the selected page and bank onto a storage slot
  always_comb begin
    slot = mgmt_mem_pkg::SLOT_P00;
    slot_ok = 1'b1;
    if (flat_mode && !paged_ok) begin
      slot = mgmt_mem_pkg::SLOT_P00;
    end else if (page_sel_ff == mgmt_mem_pkg::PAGE_00) begin
      slot = mgmt_mem_pkg::SLOT_P00;
    end else if (page_sel_ff == mgmt_mem_pkg::PAGE_01) begin
      slot = mgmt_mem_pkg::SLOT_P01;
    end else if (page_sel_ff == mgmt_mem_pkg::PAGE_02) begin
      slot = mgmt_mem_pkg::SLOT_P02;
    end else if (page_sel_ff == mgmt_mem_pkg::PAGE_10
                 && bank_sel_ff == mgmt_mem_pkg::BANK_0) begin
      slot = mgmt_mem_pkg::SLOT_P10;
    end else if (page_sel_ff == mgmt_mem_pkg::PAGE_11
                 && bank_sel_ff == mgmt_mem_pkg::BANK_0) begin
      slot = mgmt_mem_pkg::SLOT_P11;
    end else begin
      slot_ok = 1'b0; // unimplemented page or bank reads zero
    end
  end

  always_comb begin
    if (win_addr < mgmt_mem_pkg::UPPER_BASE) begin
      ram_addr = {mgmt_mem_pkg::SLOT_LOWER, win_addr[6:0]};
    end else begin
      ram_addr = {slot, win_addr[6:0]};
    end
  end

  // the selectors themselves live in the lower region
  assign sel_page_wr = req && wb_we_i && win_hit && wb_sel_i[0]
    && state_ff == mgmt_mem_pkg::BUS_IDLE
    && win_addr == {1'b0, mgmt_mem_pkg::PAGE_SEL_OFS};
  assign sel_bank_wr = req && wb_we_i && win_hit && wb_sel_i[0]
    && state_ff == mgmt_mem_pkg::BUS_IDLE
    && win_addr == {1'b0, mgmt_mem_pkg::BANK_SEL_OFS};
  assign ram_we = req && wb_we_i && win_hit && wb_sel_i[0]
    && state_ff == mgmt_mem_pkg::BUS_IDLE
    && (win_addr < mgmt_mem_pkg::UPPER_BASE || slot_ok);

  mgmt_byte_ram u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(wb_dat_i[7:0]),
    .rdata_o(ram_rdata)
  );

  // window reads wait one cycle for the memory register, other accesses ack at once
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mgmt_mem_pkg::BUS_IDLE: begin
        if (req && !wb_we_i && win_hit) begin
          nxt_state = mgmt_mem_pkg::BUS_READ;
        end else if (req) begin
          nxt_state = mgmt_mem_pkg::BUS_ACK;
        end
      end
      mgmt_mem_pkg::BUS_READ: nxt_state = mgmt_mem_pkg::BUS_ACK;
      mgmt_mem_pkg::BUS_ACK: nxt_state = mgmt_mem_pkg::BUS_IDLE;
      default: nxt_state = mgmt_mem_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= mgmt_mem_pkg::BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    nxt_dat = mgmt_mem_pkg::UNMAPPED_DATA;
    if (ctrl_hit) begin
      nxt_dat = {29'h0000_0000, ctrl_ff};
    end else if (stat_hit) begin
      nxt_dat = {28'h000_0000, lp_req_ff, rst_req_ff,
                 int_flag_ff, paged_ok};
    end else if (sel_hit) begin
      nxt_dat = {16'h0000, bank_sel_ff, page_sel_ff};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= mgmt_mem_pkg::UNMAPPED_DATA;
    end else begin
      wb_ack_o <= (nxt_state == mgmt_mem_pkg::BUS_ACK);
      if (state_ff == mgmt_mem_pkg::BUS_READ) begin
        wb_dat_o <= {24'h00_0000, (win_addr < mgmt_mem_pkg::UPPER_BASE
                     || slot_ok) ? ram_rdata : 8'h00};
      end else if (state_ff == mgmt_mem_pkg::BUS_IDLE && req) begin
        wb_dat_o <= nxt_dat;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= mgmt_mem_pkg::CTRL_RESET;
    end else if (req && wb_we_i && ctrl_hit && wb_sel_i[0]
                 && state_ff == mgmt_mem_pkg::BUS_IDLE) begin
      ctrl_ff <= wb_dat_i[2:0];
    end
  end

  // selection takes effect at the write's ack edge, so the next
  // upper-region access already sees the new page
  always_ff @(posedge clk_i) begin
    if (rst_i || rst_req_ff) begin
      page_sel_ff <= mgmt_mem_pkg::PAGE_00;
      bank_sel_ff <= mgmt_mem_pkg::BANK_0;
    end else begin
      if (sel_page_wr) begin
        page_sel_ff <= wb_dat_i[7:0];
      end else if (req && wb_we_i && sel_hit && wb_sel_i[0]
                   && state_ff == mgmt_mem_pkg::BUS_IDLE) begin
        page_sel_ff <= wb_dat_i[7:0];
      end
      if (sel_bank_wr) begin
        bank_sel_ff <= wb_dat_i[7:0];
      end else if (req && wb_we_i && sel_hit && wb_sel_i[1]
                   && state_ff == mgmt_mem_pkg::BUS_IDLE) begin
        bank_sel_ff <= wb_dat_i[15:8];
      end
    end
  end

  // sideband requests arrive active low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_req_ff <= 1'b0;
      lp_req_ff <= 1'b0;
    end else begin
      rst_req_ff <= !module_reset_input_n_i;
      lp_req_ff <= !module_lowpower_input_n_i;
    end
  end

  // interrupt is sticky; a new event wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_flag_ff <= 1'b0;
    end else if (int_event_i) begin
      int_flag_ff <= 1'b1;
    end else if (req && wb_we_i && stat_hit && wb_sel_i[0]
                 && state_ff == mgmt_mem_pkg::BUS_IDLE
                 && wb_dat_i[1]) begin
      int_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_reset_line_o <= 1'b0;
      lowpower_present_line_o <= 1'b0;
      lowpower_present_line_oe_n_o <= 1'b0;
      module_in_reset_o <= 1'b0;
      module_lowpower_o <= 1'b0;
    end else begin
      interrupt_reset_line_o <= int_flag_ff
        && ctrl_ff[mgmt_mem_pkg::CTRL_INT_BIT];
      lowpower_present_line_o <= 1'b0;
      lowpower_present_line_oe_n_o <= 1'b0;
      module_in_reset_o <= rst_req_ff;
      module_lowpower_o <= lp_req_ff;
    end
  end
endmodule

/* File: sim/module_mgmt_memory_paging_properties.sv */
// port checker for the paged management memory
// bound to every instance; sees only the block's ports
`timescale 1ns/1ps
module mgmt_mem_checker (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [11:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic module_reset_input_n_i, // reset request
  input wire logic module_lowpower_input_n_i, // low power request
  input wire logic lowpower_present_line_o, // pull-down value
  input wire logic lowpower_present_line_oe_n_o, // pull-down enable
  input wire logic module_in_reset_o, // in reset
  input wire logic module_lowpower_o // in low power
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_present;
    !lowpower_present_line_oe_n_o && !lowpower_present_line_o;
  endproperty
  // four samples cover the two-edge input pipeline
  property p_rst_on;
    !module_reset_input_n_i [*4] |-> module_in_reset_o;
  endproperty
  property p_rst_off;
    module_reset_input_n_i [*4] |-> !module_in_reset_o;
  endproperty
  property p_lp_on;
    !module_lowpower_input_n_i [*4] |-> module_lowpower_o;
  endproperty
  property p_lp_off;
    module_lowpower_input_n_i [*4] |-> !module_lowpower_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_wr_ack;
    $rose(wb_stb_i) && wb_cyc_i && wb_we_i |=> wb_ack_o;
  endproperty
  property p_rd_ack;
    $rose(wb_stb_i) && wb_cyc_i && !wb_we_i && wb_adr_i[11:10] == 2'h0
      |=> !wb_ack_o ##1 wb_ack_o;
  endproperty
  property p_rd_byte;
    wb_ack_o && !wb_we_i && wb_adr_i[11:10] == 2'h0
      |-> wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_present: assert property (p_present) else $error("no presence");
  a_rst_on: assert property (p_rst_on) else $error("no reset");
  a_rst_off: assert property (p_rst_off) else $error("stuck reset");
  a_lp_on: assert property (p_lp_on) else $error("no low power");
  a_lp_off: assert property (p_lp_off) else $error("stuck lp");
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  a_wr_ack: assert property (p_wr_ack) else $error("late write");
  a_rd_ack: assert property (p_rd_ack) else $error("read timing");
  a_rd_byte: assert property (p_rd_byte) else $error("wide byte");
  c_wr: cover property ($rose(wb_stb_i) && wb_we_i);
  c_rd: cover property (wb_ack_o && !wb_we_i);
  c_rst: cover property ($rose(module_in_reset_o));
endmodule
bind module_mgmt_memory_paging mgmt_mem_checker mgmt_mem_checker_i (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .module_reset_input_n_i, .module_lowpower_input_n_i,
  .lowpower_present_line_o, .lowpower_present_line_oe_n_o,
  .module_in_reset_o, .module_lowpower_o);

/* File: sim/host_sideband_model.sv */
// host end of the two shared sideband lines
// requests come from the bench in the same clock domain
`timescale 1ns/1ps
module host_sideband_model (
  input wire logic clk_i, // clock
  input wire logic reset_req_i, // ask module reset
  input wire logic lowpower_req_i, // ask low power
  input wire logic int_line_i, // module interrupt
  input wire logic pd_i, // pull-down value
  input wire logic pd_oe_n_i, // pull-down enable
  output logic reset_n_o, // reset, active low
  output logic lowpower_n_o, // low power, active low
  output logic int_view_o, // interrupt view
  output logic present_n_o // presence view
);
  always_ff @(posedge clk_i) begin
    reset_n_o <= !reset_req_i;
    lowpower_n_o <= !lowpower_req_i;
  end
  assign int_view_o = int_line_i;
  // host pull-up wins unless the module pulls down
  assign present_n_o = pd_oe_n_i ? 1'b1 : pd_i;
endmodule

/* File: sim/module_mgmt_memory_paging_test.sv */
// self-checking bench for the paged management memory
// wishbone driven here, sidebands through the host model
`timescale 1ns/1ps
module module_mgmt_memory_paging_test;
  typedef struct packed {
    logic we;
    logic [11:0] a;
    logic [15:0] d;
  } row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ev = 1'b0;
  logic rreq = 1'b0, lreq = 1'b0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, irq, hirq, pd, pd_oe_n, in_rst, in_lp, rst_n, lp_n, prs_n;
  wire [2:0] side = {in_lp, in_rst, hirq};
  int fail_count = 0;
  int compares = 0;
  // upper accesses use the last selected page and bank, except the first, which uses the reset page, and the flat-mode read, which gets page 00
  row_s rows [31] = '{
    '{1, 12'h040, 16'h00a5}, '{1, 12'h200, 16'h0044},
    '{1, 12'h1fc, 16'h0001}, '{1, 12'h200, 16'h0011},
    '{1, 12'h1fc, 16'h0002}, '{1, 12'h200, 16'h0022},
    '{1, 12'h1fc, 16'h0010}, '{1, 12'h200, 16'h0033},
    '{1, 12'h1fc, 16'h0011}, '{1, 12'h200, 16'h0055},
    '{1, 12'h1fc, 16'h0001}, '{0, 12'h200, 16'h0011},
    '{0, 12'h040, 16'h00a5}, '{1, 12'h1fc, 16'h0002},
    '{0, 12'h200, 16'h0022}, '{1, 12'h1fc, 16'h0011},
    '{0, 12'h200, 16'h0055}, '{1, 12'h1fc, 16'h0010},
    '{1, 12'h1f8, 16'h0001}, '{0, 12'h200, 16'h0000},
    '{0, 12'h408, 16'h0110}, '{1, 12'h1f8, 16'h0000},
    '{0, 12'h200, 16'h0033}, '{1, 12'h1fc, 16'h0003},
    '{1, 12'h200, 16'h0077}, '{0, 12'h200, 16'h0000},
    '{0, 12'h800, 16'h0000}, '{1, 12'h1fc, 16'h0001},
    '{1, 12'h400, 16'h0001}, '{0, 12'h200, 16'h0044},
    '{1, 12'h400, 16'h0005}};
  always #4 clk_i = ~clk_i;
  module_mgmt_memory_paging module_mgmt_memory_paging_i (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .module_reset_input_n_i(rst_n),
    .module_lowpower_input_n_i(lp_n), .int_event_i(ev),
    .interrupt_reset_line_o(irq), .lowpower_present_line_o(pd),
    .lowpower_present_line_oe_n_o(pd_oe_n), .module_in_reset_o(in_rst),
    .module_lowpower_o(in_lp));
  host_sideband_model host_sideband_model_i (
    .clk_i, .reset_req_i(rreq), .lowpower_req_i(lreq), .int_line_i(irq),
    .pd_i(pd), .pd_oe_n_i(pd_oe_n), .reset_n_o(rst_n),
    .lowpower_n_o(lp_n), .int_view_o(hirq), .present_n_o(prs_n));
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb, we} <= 3'h0;
    if (n == 20) begin
      fail_count++;
      test_done;
    end
  endtask
  task automatic await(input int k, input logic e);
    int n;
    n = 0;
    while (side[k] !== e && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, side[k]}, {31'h0, e});
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 31; i++) begin
      bus(rows[i].we, rows[i].a, {16'h0, rows[i].d});
      if (!rows[i].we) chk(q, {16'h0, rows[i].d});
    end
    bus(1'b0, 12'h200, 32'h0);
    chk(q, 32'h11);
    $display("paging test done");
    bus(1'b1, 12'h400, 32'h2);
    ev <= 1'b1;
    @(posedge clk_i);
    ev <= 1'b0;
    await(0, 1'b1);
    bus(1'b1, 12'h404, 32'h2);
    await(0, 1'b0);
    bus(1'b1, 12'h400, 32'h0);
    ev <= 1'b1;
    @(posedge clk_i);
    ev <= 1'b0;
    repeat (6) @(posedge clk_i);
    await(0, 1'b0);
    // the flag is sticky, so enabling later still raises the line
    bus(1'b1, 12'h400, 32'h2);
    await(0, 1'b1);
    bus(1'b1, 12'h404, 32'h2);
    await(0, 1'b0);
    $display("interrupt test done");
    rreq <= 1'b1;
    await(1, 1'b1);
    bus(1'b0, 12'h408, 32'h0);
    chk(q, 32'h0);
    rreq <= 1'b0;
    await(1, 1'b0);
    lreq <= 1'b1;
    await(2, 1'b1);
    lreq <= 1'b0;
    await(2, 1'b0);
    chk({31'h0, prs_n}, 32'h0);
    $display("sideband test done");
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({29'h0, side}, 32'h0);
    bus(1'b0, 12'h400, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
    test_done;
  end
endmodule
